//--- shared/mq_fifo_pkg.sv
// Purpose: shared constants for the multi-queue fifo core and its host end
// Assumes: one clock for both ports, queue select width 2
// Notes: register map belongs to the host end, reached over apb
// Functional notes
// R1: one to four queues, shared ports
// R2: storage in blocks of 256 36-bit words
// R3: each queue zero to all blocks
// R4: pool of 64, 128 or 256 blocks
// R5: port widths 9/18/36, one is 36
// R6: widths global to all queues
// R7: writer selects queue; writes go there only
// R8: reader selects queue; data only from it
// R9: write and read ports fully independent
// R10: one clock and enable per port; here both ports share the one clk_sys, each with its own enable
// R11: enabled write edge stores word in order
// R12: output updates on read clock edge
// R13: no write when full; full shows selection
// R14: selected queue's head falls through automatically
// R15: later words need an enabled read
// R16: empty queue gives nothing; valid flag shown
// R17: switch to empty queue keeps last word
// R18: per-queue almost-full offset, selected queue shown
// R19: per-queue almost-empty offset, selected queue shown
// R20: master reset captures setup, precedes programming
// R21: single queue reset needs both selects
// R22: almost flags compare free space and count
// R23: configuration held stable while data moves
package mq_fifo_pkg;
	localparam int WORD_W = 36;
	localparam int WIDTH_BYTE = 9;
	localparam int WIDTH_HALF = 18;
	localparam int BLOCK_WORDS = 256;
	localparam int QUEUES_MAX = 4;
	localparam int QSEL_W = 2;
	localparam int QCNT_W = 3;
	localparam int BLK_W = 9;
	localparam int OFS_W = 16;
	localparam int LANE_W = 2;
	localparam int POOL_SMALL = 64;
	localparam int POOL_MID = 128;
	localparam int POOL_LARGE = 256;
	localparam int POOL_DEFAULT = POOL_SMALL;
	localparam logic [OFS_W-1:0] RST_AF_OFS = 16'h0010;
	localparam logic [OFS_W-1:0] RST_AE_OFS = 16'h0010;

	localparam int APB_AW = 8;
	localparam int APB_DW = 32;
	localparam int HI_W = WORD_W - APB_DW;
	localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] ADDR_WDATA_HI = 8'h08;
	localparam logic [APB_AW-1:0] ADDR_WDATA = 8'h0c;
	localparam logic [APB_AW-1:0] ADDR_RDATA_HI = 8'h10;
	localparam logic [APB_AW-1:0] ADDR_RDATA = 8'h14;
	localparam logic [APB_AW-1:0] ADDR_ALLOC0 = 8'h20;
	localparam logic [APB_AW-1:0] ADDR_THRESH0 = 8'h30;
	localparam int ADDR_STRIDE = 4;
	localparam int CTRL_MRESET_BIT = 0;
	localparam int CTRL_QRESET_BIT = 1;
	localparam int CTRL_WSEL_LSB = 4;
	localparam int CTRL_RSEL_LSB = 8;
	localparam int CTRL_QCNT_LSB = 12;
	localparam int ST_FULL_BIT = 0;
	localparam int ST_AFULL_BIT = 1;
	localparam int ST_VALID_BIT = 2;
	localparam int ST_AEMPTY_BIT = 3;
	localparam int THRESH_AE_LSB = 16;

	function automatic bit width_ok(input int w);
		return w == WIDTH_BYTE || w == WIDTH_HALF || w == WORD_W;
	endfunction : width_ok

	function automatic bit pool_ok(input int p);
		return p == POOL_SMALL || p == POOL_MID || p == POOL_LARGE;
	endfunction : pool_ok
endpackage : mq_fifo_pkg

//--- shared/mq_link_if.sv
// Purpose: link between the fifo device end and its host end
// Assumes: both ends on clk_sys
// Notes: cfg signals are sampled only while masterReset is high
`timescale 1ns/1ns
interface mq_link_if
	import mq_fifo_pkg::*;
#(
	parameter int IN_WIDTH = WORD_W,
	parameter int OUT_WIDTH = WORD_W
);
	logic writeEnable;
	logic [IN_WIDTH-1:0] writeData;
	logic [QSEL_W-1:0] writeQueueSelect;
	logic readEnable;
	logic [QSEL_W-1:0] readQueueSelect;
	logic [OUT_WIDTH-1:0] readData;
	logic queueFullFlag;
	logic almostFullFlag;
	logic outputValidFlag;
	logic almostEmptyFlag;
	logic masterReset;
	logic singleQueueReset;
	logic [QCNT_W-1:0] cfgQueues;
	logic [BLK_W-1:0] cfgBlocks [QUEUES_MAX];
	logic [OFS_W-1:0] cfgAlmostFull [QUEUES_MAX];
	logic [OFS_W-1:0] cfgAlmostEmpty [QUEUES_MAX];

	modport device (
		input writeEnable, writeData, writeQueueSelect, readEnable, readQueueSelect,
		input masterReset, singleQueueReset, cfgQueues, cfgBlocks, cfgAlmostFull, cfgAlmostEmpty,
		output readData, queueFullFlag, almostFullFlag, outputValidFlag, almostEmptyFlag
	);
	modport host (
		output writeEnable, writeData, writeQueueSelect, readEnable, readQueueSelect,
		output masterReset, singleQueueReset, cfgQueues, cfgBlocks, cfgAlmostFull, cfgAlmostEmpty,
		input readData, queueFullFlag, almostFullFlag, outputValidFlag, almostEmptyFlag
	);
endinterface : mq_link_if

//--- core/mq_fifo_device.sv
// Purpose: multi-queue fifo, standard write port, fall-through read port
// Assumes: both ports on clk_sys; link inputs come from logic on clk_sys
// Notes: queues laid out back to back in one array, in queue order
//
// Design decisions made in the host end: register access over APB and the address map.
`timescale 1ns/1ns
module mq_fifo_device
	import mq_fifo_pkg::*;
#(
	parameter int IN_WIDTH = WORD_W,
	parameter int OUT_WIDTH = WORD_W,
	parameter int POOL_BLOCKS = POOL_DEFAULT
)
(
	input wire logic clk_sys,
	input wire logic rst,
	mq_link_if.device link,
	output logic [QCNT_W-1:0] activeQueues
);
	localparam int IN_LANES = WORD_W / IN_WIDTH;
	localparam int OUT_LANES = WORD_W / OUT_WIDTH;
	localparam int DEPTH = POOL_BLOCKS * BLOCK_WORDS;
	localparam int ADDR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [LANE_W-1:0] IN_LAST = LANE_W'(IN_LANES - 1);
	localparam logic [LANE_W-1:0] OUT_LAST = LANE_W'(OUT_LANES - 1);
	localparam logic [BLK_W-1:0] RST_BLOCKS = BLK_W'(POOL_BLOCKS / QUEUES_MAX);

	generate
		if (!width_ok(IN_WIDTH) || !width_ok(OUT_WIDTH)) // R5
		begin : badWidth
			$error("port width must be 9, 18 or 36");
		end
		if (IN_WIDTH != WORD_W && OUT_WIDTH != WORD_W) // R5
		begin : noFullPort
			$error("one port must be 36 bits wide");
		end
		if (!pool_ok(POOL_BLOCKS)) // R4
		begin : badPool
			$error("pool must be 64, 128 or 256 blocks");
		end
	endgenerate

	logic [BLK_W-1:0] blocksQ [QUEUES_MAX];
	logic [OFS_W-1:0] afOfsQ [QUEUES_MAX];
	logic [OFS_W-1:0] aeOfsQ [QUEUES_MAX];
	logic [QCNT_W-1:0] queuesQ;
	logic [ADDR_W-1:0] headQ [QUEUES_MAX];
	logic [ADDR_W-1:0] tailQ [QUEUES_MAX];
	logic [CNT_W-1:0] cntQ [QUEUES_MAX];
	logic [CNT_W-1:0] cntD [QUEUES_MAX];
	logic [CNT_W-1:0] capWords [QUEUES_MAX];
	logic [ADDR_W-1:0] baseAddr [QUEUES_MAX];
	logic [WORD_W-1:0] mem [DEPTH];
	logic [WORD_W-1:0] packQ;
	logic [WORD_W-1:0] packD;
	logic [LANE_W-1:0] wrLaneQ;
	logic [LANE_W-1:0] rdLaneQ;
	logic [WORD_W-1:0] outWordQ;
	logic validQ;
	logic [QSEL_W-1:0] ownerQ;
	logic fullQ;
	logic afQ;
	logic aeQ;
	logic [QSEL_W-1:0] wrSel;
	logic [QSEL_W-1:0] rdSel;
	logic qReset;
	logic wrFull;
	logic wrAccept;
	logic wrStore;
	logic consume;
	logic pop;
	logic popSel;
	logic rdAvail;
	logic needLoad;
	logic [ADDR_W-1:0] selHead;
	logic [ADDR_W-1:0] loadAddr;

	function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] p, input logic [CNT_W-1:0] cap);
		return (CNT_W'(p) + CNT_W'(1) >= cap) ? '0 : p + ADDR_W'(1);
	endfunction : step

	// carve queues from the pool; an overcommitted queue gets no blocks
	always_comb
	begin
		int run;
		int words;
		run = 0;
		words = 0;
		for (int q = 0; q < QUEUES_MAX; q++)
		begin
			words = (q < int'(queuesQ)) ? int'(blocksQ[q]) * BLOCK_WORDS : 0; // R1 R2 R3
			if (run + words > DEPTH) // R4
				words = 0;
			capWords[q] = CNT_W'(words);
			baseAddr[q] = ADDR_W'(run);
			run = run + words;
		end
	end

	assign wrSel = link.writeQueueSelect; // R7
	assign rdSel = link.readQueueSelect; // R8
	assign qReset = link.singleQueueReset && (wrSel == rdSel); // R21
	assign wrFull = cntQ[wrSel] >= capWords[wrSel];
	assign wrAccept = link.writeEnable && !wrFull && !link.masterReset && !qReset; // R11 R13
	assign wrStore = wrAccept && (wrLaneQ == IN_LAST);
	assign packD = WORD_W'({link.writeData, packQ} >> IN_WIDTH); // R5 R6
	assign consume = link.readEnable && validQ && !link.masterReset; // R15 R16
	assign pop = consume && (rdLaneQ == OUT_LAST) && !(qReset && ownerQ == wrSel);
	assign popSel = pop && (ownerQ == rdSel);
	assign selHead = popSel ? step(headQ[rdSel], capWords[rdSel]) : headQ[rdSel];
	assign rdAvail = !qReset && (cntQ[rdSel] > CNT_W'(popSel)); // R16
	assign needLoad = (ownerQ != rdSel) || !validQ || pop || qReset; // R14
	assign loadAddr = ADDR_W'(baseAddr[rdSel] + selHead);

	always_comb
	begin
		for (int q = 0; q < QUEUES_MAX; q++)
		begin
			cntD[q] = cntQ[q];
			if (wrStore && wrSel == QSEL_W'(q))
				cntD[q] = cntD[q] + CNT_W'(1);
			if (pop && ownerQ == QSEL_W'(q))
				cntD[q] = cntD[q] - CNT_W'(1);
			if (link.masterReset || (qReset && wrSel == QSEL_W'(q))) // R21
				cntD[q] = '0;
		end
	end

	// configuration only moves under master reset
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			queuesQ <= QCNT_W'(QUEUES_MAX);
			for (int q = 0; q < QUEUES_MAX; q++)
			begin
				blocksQ[q] <= RST_BLOCKS;
				afOfsQ[q] <= RST_AF_OFS;
				aeOfsQ[q] <= RST_AE_OFS;
			end
		end
		else if (link.masterReset) // R20 R23
		begin
			queuesQ <= link.cfgQueues;
			for (int q = 0; q < QUEUES_MAX; q++)
			begin
				blocksQ[q] <= link.cfgBlocks[q];
				afOfsQ[q] <= link.cfgAlmostFull[q];
				aeOfsQ[q] <= link.cfgAlmostEmpty[q];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			for (int q = 0; q < QUEUES_MAX; q++)
			begin
				headQ[q] <= '0;
				tailQ[q] <= '0;
				cntQ[q] <= '0;
			end
		end
		else
		begin
			for (int q = 0; q < QUEUES_MAX; q++)
			begin
				cntQ[q] <= cntD[q];
				if (link.masterReset || (qReset && wrSel == QSEL_W'(q))) // R21
				begin
					headQ[q] <= '0;
					tailQ[q] <= '0;
				end
				else
				begin
					if (wrStore && wrSel == QSEL_W'(q)) // R9 R11
						tailQ[q] <= step(tailQ[q], capWords[q]);
					if (pop && ownerQ == QSEL_W'(q)) // R9
						headQ[q] <= step(headQ[q], capWords[q]);
				end
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (wrStore)
			mem[ADDR_W'(baseAddr[wrSel] + tailQ[wrSel])] <= packD; // R7 R11
	end

	// narrow input lanes gather low lane first
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			wrLaneQ <= '0;
			packQ <= '0;
		end
		else if (link.masterReset || qReset)
			wrLaneQ <= '0;
		else if (wrAccept) // R10
		begin
			packQ <= packD;
			wrLaneQ <= wrStore ? '0 : wrLaneQ + LANE_W'(1);
		end
	end

	// output register: loaded head word is popped only when fully read
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			validQ <= 1'b0;
			ownerQ <= '0;
			outWordQ <= '0;
			rdLaneQ <= '0;
		end
		else if (link.masterReset)
		begin
			validQ <= 1'b0;
			rdLaneQ <= '0;
		end
		else if (needLoad) // R12 R14
		begin
			rdLaneQ <= '0;
			ownerQ <= rdSel;
			validQ <= rdAvail; // R16
			if (rdAvail)
				outWordQ <= mem[loadAddr]; // R8 R17
		end
		else if (consume) // R15
		begin
			outWordQ <= outWordQ >> OUT_WIDTH;
			rdLaneQ <= rdLaneQ + LANE_W'(1);
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			fullQ <= 1'b0;
			afQ <= 1'b0;
			aeQ <= 1'b1;
		end
		else
		begin
			fullQ <= cntD[wrSel] >= capWords[wrSel]; // R13
			afQ <= int'(capWords[wrSel]) - int'(cntD[wrSel]) <= int'(afOfsQ[wrSel]); // R18 R22
			aeQ <= int'(cntD[rdSel]) <= int'(aeOfsQ[rdSel]); // R19 R22
		end
	end

	assign link.readData = outWordQ[OUT_WIDTH-1:0];
	assign link.queueFullFlag = fullQ;
	assign link.almostFullFlag = afQ;
	assign link.outputValidFlag = validQ;
	assign link.almostEmptyFlag = aeQ;
	assign activeQueues = queuesQ;
endmodule : mq_fifo_device

//--- core/mq_fifo_host.sv
// Purpose: apb-controlled writer and reader for the multi-queue fifo
// Assumes: apb master on clk_sys; one wait state per transfer
// Notes: data wider than 32 bits is staged through the hi registers
`timescale 1ns/1ns
module mq_fifo_host
	import mq_fifo_pkg::*;
#(
	parameter int IN_WIDTH = WORD_W,
	parameter int OUT_WIDTH = WORD_W,
	parameter int POOL_BLOCKS = POOL_DEFAULT
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [APB_DW-1:0] pwdata,
	output logic [APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	mq_link_if.host link
);
	generate
		if (!width_ok(IN_WIDTH) || !width_ok(OUT_WIDTH) || !pool_ok(POOL_BLOCKS))
		begin : badParam
			$error("unsupported width or pool size");
		end
	endgenerate

	logic mresetQ;
	logic qresetQ;
	logic [QSEL_W-1:0] wselQ;
	logic [QSEL_W-1:0] rselQ;
	logic [QCNT_W-1:0] queuesQ;
	logic [BLK_W-1:0] allocQ [QUEUES_MAX];
	logic [OFS_W-1:0] afOfsQ [QUEUES_MAX];
	logic [OFS_W-1:0] aeOfsQ [QUEUES_MAX];
	logic [HI_W-1:0] wrHiQ;
	logic wrEnQ;
	logic [IN_WIDTH-1:0] wrDataQ;
	logic rdEnQ;
	logic preadyQ;
	logic [APB_DW-1:0] prdataQ;
	logic pslverrQ;
	logic [APB_DW-1:0] rdWord;
	logic hit;
	logic acc;
	logic [WORD_W-1:0] rdWide;

	assign acc = psel && penable && preadyQ;
	assign rdWide = WORD_W'(link.readData);

	always_comb
	begin
		hit = 1'b1;
		rdWord = '0;
		case (paddr)
			ADDR_CTRL: rdWord = (APB_DW'(mresetQ) << CTRL_MRESET_BIT) | (APB_DW'(wselQ) << CTRL_WSEL_LSB)
				| (APB_DW'(rselQ) << CTRL_RSEL_LSB) | (APB_DW'(queuesQ) << CTRL_QCNT_LSB);
			ADDR_STATUS: rdWord = (APB_DW'(link.queueFullFlag) << ST_FULL_BIT)
				| (APB_DW'(link.almostFullFlag) << ST_AFULL_BIT)
				| (APB_DW'(link.outputValidFlag) << ST_VALID_BIT)
				| (APB_DW'(link.almostEmptyFlag) << ST_AEMPTY_BIT);
			ADDR_WDATA_HI: rdWord = APB_DW'(wrHiQ);
			ADDR_WDATA: rdWord = '0;
			ADDR_RDATA_HI: rdWord = APB_DW'(rdWide[WORD_W-1:APB_DW]);
			ADDR_RDATA: rdWord = rdWide[APB_DW-1:0];
			default:
			begin
				hit = 1'b0;
				for (int q = 0; q < QUEUES_MAX; q++)
				begin
					if (paddr == APB_AW'(int'(ADDR_ALLOC0) + q * ADDR_STRIDE))
					begin
						hit = 1'b1;
						rdWord = APB_DW'(allocQ[q]);
					end
					if (paddr == APB_AW'(int'(ADDR_THRESH0) + q * ADDR_STRIDE))
					begin
						hit = 1'b1;
						rdWord = APB_DW'(afOfsQ[q]) | (APB_DW'(aeOfsQ[q]) << THRESH_AE_LSB);
					end
				end
			end
		endcase
	end

	// one wait state: data captured in first access cycle
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			preadyQ <= 1'b0;
			prdataQ <= '0;
			pslverrQ <= 1'b0;
		end
		else if (psel && penable && !preadyQ)
		begin
			preadyQ <= 1'b1;
			prdataQ <= pwrite ? '0 : rdWord;
			pslverrQ <= !hit;
		end
		else
			preadyQ <= 1'b0;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			mresetQ <= 1'b0;
			wselQ <= '0;
			rselQ <= '0;
			queuesQ <= QCNT_W'(QUEUES_MAX);
			wrHiQ <= '0;
			for (int q = 0; q < QUEUES_MAX; q++)
			begin
				allocQ[q] <= BLK_W'(POOL_BLOCKS / QUEUES_MAX);
				afOfsQ[q] <= RST_AF_OFS;
				aeOfsQ[q] <= RST_AE_OFS;
			end
		end
		else if (acc && pwrite && hit)
		begin
			if (paddr == ADDR_CTRL)
			begin
				mresetQ <= pwdata[CTRL_MRESET_BIT]; // R20
				wselQ <= pwdata[CTRL_WSEL_LSB +: QSEL_W]; // R7
				rselQ <= pwdata[CTRL_RSEL_LSB +: QSEL_W]; // R8
				queuesQ <= pwdata[CTRL_QCNT_LSB +: QCNT_W];
			end
			if (paddr == ADDR_WDATA_HI)
				wrHiQ <= pwdata[HI_W-1:0];
			for (int q = 0; q < QUEUES_MAX; q++)
			begin
				if (paddr == APB_AW'(int'(ADDR_ALLOC0) + q * ADDR_STRIDE))
					allocQ[q] <= pwdata[BLK_W-1:0];
				if (paddr == APB_AW'(int'(ADDR_THRESH0) + q * ADDR_STRIDE))
				begin
					afOfsQ[q] <= pwdata[OFS_W-1:0];
					aeOfsQ[q] <= pwdata[THRESH_AE_LSB +: OFS_W];
				end
			end
		end
	end

	// link strobes: one-cycle pulses after the completing apb edge
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			wrEnQ <= 1'b0;
			wrDataQ <= '0;
			rdEnQ <= 1'b0;
			qresetQ <= 1'b0;
		end
		else
		begin
			wrEnQ <= acc && pwrite && paddr == ADDR_WDATA && !link.queueFullFlag; // R13
			if (acc && pwrite && paddr == ADDR_WDATA)
				wrDataQ <= IN_WIDTH'({wrHiQ, pwdata});
			rdEnQ <= acc && !pwrite && paddr == ADDR_RDATA && link.outputValidFlag; // R15
			qresetQ <= acc && pwrite && paddr == ADDR_CTRL && pwdata[CTRL_QRESET_BIT]
				&& pwdata[CTRL_WSEL_LSB +: QSEL_W] == pwdata[CTRL_RSEL_LSB +: QSEL_W]; // R21
		end
	end

	assign prdata = prdataQ;
	assign pready = preadyQ;
	assign pslverr = pslverrQ;
	assign link.writeEnable = wrEnQ;
	assign link.writeData = wrDataQ;
	assign link.writeQueueSelect = wselQ;
	assign link.readEnable = rdEnQ;
	assign link.readQueueSelect = rselQ;
	assign link.masterReset = mresetQ;
	assign link.singleQueueReset = qresetQ;
	assign link.cfgQueues = queuesQ;
	assign link.cfgBlocks = allocQ;
	assign link.cfgAlmostFull = afOfsQ;
	assign link.cfgAlmostEmpty = aeOfsQ;
endmodule : mq_fifo_host

//--- sim/mq_fifo_props.sv
// Purpose: link-side checks between the fifo device end and its host end
// Assumes: one clock domain, rst async active high
// Notes: flags reflect the select of the previous cycle
`timescale 1ns/1ns
module mq_fifo_props
	import mq_fifo_pkg::*;
#(
	parameter int IN_WIDTH = WORD_W,
	parameter int OUT_WIDTH = WORD_W
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic writeEnable,
	input wire logic [IN_WIDTH-1:0] writeData,
	input wire logic [QSEL_W-1:0] writeQueueSelect,
	input wire logic readEnable,
	input wire logic [QSEL_W-1:0] readQueueSelect,
	input wire logic [OUT_WIDTH-1:0] readData,
	input wire logic queueFullFlag,
	input wire logic almostFullFlag,
	input wire logic outputValidFlag,
	input wire logic almostEmptyFlag,
	input wire logic masterReset,
	input wire logic singleQueueReset
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	wire noRst = !masterReset && !singleQueueReset;

	sequence s_quiet;
		!writeEnable;
	endsequence
	sequence s_push;
		writeEnable && !queueFullFlag && !outputValidFlag && writeQueueSelect == readQueueSelect
			&& $stable(readQueueSelect) && $stable(writeQueueSelect) && noRst;
	endsequence
	sequence s_settle;
		$stable(readQueueSelect) && noRst;
	endsequence

	property p_fall_through;
		s_quiet ##1 s_push ##1 s_settle |=> outputValidFlag && readData == $past(writeData, 2);
	endproperty
	a_fall_through: assert property (p_fall_through) else $error("pushed word did not fall through");
	property p_full_af;
		queueFullFlag |-> almostFullFlag;
	endproperty
	a_full_af: assert property (p_full_af) else $error("full without almost full");
	property p_full_hold;
		queueFullFlag && !readEnable && $stable(writeQueueSelect) && noRst |=> queueFullFlag;
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("full dropped without a read");
	property p_word_hold;
		outputValidFlag && !readEnable && $stable(readQueueSelect) && noRst |=> outputValidFlag && $stable(readData);
	endproperty
	a_word_hold: assert property (p_word_hold) else $error("output word moved without a read");
	property p_last_word;
		(!outputValidFlag && noRst) ##1 !outputValidFlag |-> $stable(readData);
	endproperty
	a_last_word: assert property (p_last_word) else $error("output changed while not valid");
	property p_ae_hold;
		almostEmptyFlag && !writeEnable && $stable(readQueueSelect) && noRst |=> almostEmptyFlag;
	endproperty
	a_ae_hold: assert property (p_ae_hold) else $error("almost empty fell without a write");
	property p_mreset;
		masterReset |=> !outputValidFlag && almostEmptyFlag;
	endproperty
	a_mreset: assert property (p_mreset) else $error("queues not emptied by master reset");
	property p_qreset;
		singleQueueReset && writeQueueSelect == readQueueSelect && $stable(readQueueSelect) && !masterReset
			|=> !outputValidFlag && almostEmptyFlag;
	endproperty
	a_qreset: assert property (p_qreset) else $error("selected queue not emptied");
endmodule : mq_fifo_props

//--- sim/multi_queue_fifo_core_tb.sv
// Purpose: apb-driven bench for host and device ends joined by the link
// Assumes: default widths 36/36, pool of 64 blocks
// Notes: words go hi register first, then low word
`timescale 1ns/1ns
module multi_queue_fifo_core_tb
	import mq_fifo_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = 8'h00;
	logic [APB_DW-1:0] pwdata = 32'h0;
	logic [APB_DW-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [QCNT_W-1:0] activeQueues;
	logic [QCNT_W-1:0] qc = 3'h4;
	int errCount = 0;
	int nTests = 0;

	always #10 clk_sys = ~clk_sys;

	mq_link_if link ();
	mq_fifo_device u_mq_fifo_device (.clk_sys(clk_sys), .rst(rst), .link(link), .activeQueues(activeQueues));
	mq_fifo_host u_mq_fifo_host (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	mq_fifo_props u_mq_fifo_props (.clk_sys(clk_sys), .rst(rst), .writeEnable(link.writeEnable),
		.writeData(link.writeData), .writeQueueSelect(link.writeQueueSelect),
		.readEnable(link.readEnable), .readQueueSelect(link.readQueueSelect), .readData(link.readData),
		.queueFullFlag(link.queueFullFlag), .almostFullFlag(link.almostFullFlag),
		.outputValidFlag(link.outputValidFlag), .almostEmptyFlag(link.almostEmptyFlag),
		.masterReset(link.masterReset), .singleQueueReset(link.singleQueueReset));

	task conclude;
		if (errCount == 0 && nTests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	task chk(input logic [35:0] got, input logic [35:0] exp);
		nTests++;
		if (got !== exp)
		begin
			errCount++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		@(posedge clk_sys);
		while (pready !== 1'b1)
		begin
			@(posedge clk_sys);
			n++;
		end
		r = prdata;
		e = pslverr;
		chk(36'(n), 36'h1); // one wait state per transfer
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask : rd

	task ctrl(input logic mr, input logic qr, input logic [1:0] ws, input logic [1:0] rs);
		wr(ADDR_CTRL, (32'(mr) << CTRL_MRESET_BIT) | (32'(qr) << CTRL_QRESET_BIT) | (32'(ws) << CTRL_WSEL_LSB)
			| (32'(rs) << CTRL_RSEL_LSB) | (32'(qc) << CTRL_QCNT_LSB));
	endtask : ctrl

	function automatic logic [35:0] wv(input int i);
		return 36'h5_a5a5_0000 ^ (36'(i) * 36'h1_0001_0003);
	endfunction : wv

	task push(input logic [35:0] w);
		wr(ADDR_WDATA_HI, 32'(w[35:32]));
		wr(ADDR_WDATA, w[31:0]);
	endtask : push

	task pop(input logic [35:0] exp);
		logic [31:0] h;
		logic [31:0] l;
		rd(ADDR_RDATA_HI, h);
		rd(ADDR_RDATA, l);
		chk({h[3:0], l}, exp);
	endtask : pop

	// expected order: almost empty, valid, almost full, full
	task status(input logic [3:0] exp);
		logic [31:0] r;
		rd(ADDR_STATUS, r);
		chk(36'(r[3:0]), 36'(exp));
	endtask : status

	task t_unmapped;
		logic [31:0] r;
		logic e;
		apb(1'b0, 8'hfc, 32'h0, r, e);
		chk(36'(e), 36'h1);
		chk(36'(r), 36'h0);
	endtask : t_unmapped

	task t_first_word_fall_through;
		ctrl(1'b0, 1'b0, 2'h1, 2'h1);
		status(4'b1000);
		for (int i = 1; i <= 3; i++)
			push(wv(i));
		status(4'b1100);
		for (int i = 1; i <= 3; i++)
			pop(wv(i));
		status(4'b1000);
	endtask : t_first_word_fall_through

	task t_indep;
		push(wv(6));
		ctrl(1'b0, 1'b0, 2'h2, 2'h1);
		push(wv(7));
		push(wv(8));
		ctrl(1'b0, 1'b0, 2'h2, 2'h3);
		status(4'b1000);
		pop(wv(6));
		ctrl(1'b0, 1'b0, 2'h2, 2'h1);
		pop(wv(6));
		ctrl(1'b0, 1'b0, 2'h2, 2'h2);
		pop(wv(7));
		pop(wv(8));
	endtask : t_indep

	task t_qreset;
		ctrl(1'b0, 1'b0, 2'h0, 2'h0);
		push(wv(20));
		push(wv(21));
		ctrl(1'b0, 1'b1, 2'h0, 2'h0);
		status(4'b1000);
		push(wv(22));
		pop(wv(22));
	endtask : t_qreset

	task t_full;
		logic [31:0] r;
		wr(ADDR_ALLOC0, 32'h1);
		wr(ADDR_ALLOC0 + 8'h04, 32'h0);
		wr(ADDR_ALLOC0 + 8'h08, 32'h1);
		wr(ADDR_ALLOC0 + 8'h0c, 32'h1);
		wr(ADDR_THRESH0, {16'h0001, 16'h0002});
		rd(ADDR_THRESH0, r);
		chk(36'(r), 36'h0_0001_0002);
		rd(ADDR_ALLOC0 + 8'h04, r);
		chk(36'(r), 36'h0);
		qc = 3'h3;
		ctrl(1'b1, 1'b0, 2'h0, 2'h0);
		rd(ADDR_CTRL, r);
		chk(36'(r), 36'h3001);
		ctrl(1'b0, 1'b0, 2'h1, 2'h1);
		chk(36'(activeQueues), 36'(qc));
		status(4'b1011);
		ctrl(1'b0, 1'b0, 2'h3, 2'h3);
		status(4'b1011);
		ctrl(1'b0, 1'b0, 2'h0, 2'h2);
		for (int i = 0; i < 253; i++)
			push(wv(i));
		status(4'b1000);
		push(wv(253));
		status(4'b1010);
		push(wv(254));
		push(wv(255));
		status(4'b1011);
		push(wv(999));
		ctrl(1'b0, 1'b0, 2'h0, 2'h0);
		status(4'b0111);
		for (int i = 0; i < 255; i++)
			pop(wv(i));
		status(4'b1100);
		pop(wv(255));
		status(4'b1000);
	endtask : t_full

	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		t_unmapped();
		t_first_word_fall_through();
		t_indep();
		t_qreset();
		t_full();
		conclude();
	end

	// run needs about 4400 cycles
	initial
	begin
		#400000;
		errCount++;
		conclude();
	end
endmodule : multi_queue_fifo_core_tb
